// *** rtl/sfl_chan.sv ***
// one half-bridge channel: programmed bits, latched-off fault, output drive
module sfl_chan
    import sfl_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // programming
    input wire logic wr_cfg,
    input wire logic wr_en_bit,
    input wire logic wr_cfg_bit,
    // faults
    input wire logic fault_set,
    input wire logic fault_clr,
    input wire logic lockout,
    // state
    output logic en_ff,
    output logic cfg_ff,
    output logic latched_ff,
    output logic drive_ff,
    output logic side_ff
);
    // a latching fault wins over a same-cycle write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            en_ff <= 1'b0;
            cfg_ff <= 1'b0;
        end else if (ce) begin
            if (fault_set) begin
                en_ff <= 1'b0;
                cfg_ff <= 1'b0;
            end else if (wr_cfg) begin
                en_ff <= wr_en_bit;
                cfg_ff <= wr_cfg_bit;
            end
        end
    end

    // set beats clear so a fault arriving during a clear survives
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            latched_ff <= 1'b0;
        end else if (ce) begin
            if (fault_set) begin
                latched_ff <= 1'b1;
            end else if (fault_clr) begin
                latched_ff <= 1'b0;
            end
        end
    end

    // lockout only masks the drive; programmed bits are kept for recovery
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            drive_ff <= 1'b0;
            side_ff <= 1'b0;
        end else if (ce) begin
            drive_ff <= en_ff & ~latched_ff & ~lockout;
            side_ff <= cfg_ff;
        end
    end
endmodule

// *** rtl/sfl_pkg.sv ***
// constants for the supply-fault lockout block
// Operation
// - lockout select 0: over-voltage leaves outputs unchanged, drivers may stay on.
// - lockout select 1: over-voltage puts all drivers high-Z, auto-recovers afterwards.
// - under-voltage puts all drivers high-Z unlatched, resumes prior state afterwards.
// - latched faults clear on status reset request, enable cycle or power-on.
// - latching fault disables half-bridge, zeroes its enable and config bits.
// - locked-out driver returns to programmed state once cause disappears.
package sfl_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int SFL_AW = 4;
    localparam int SFL_DW = 32;
    localparam logic [3:0] SFL_CTRL_OFS = 4'h0;
    localparam logic [3:0] SFL_HBCFG_OFS = 4'h4;
    localparam logic [3:0] SFL_STAT_OFS = 4'h8;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SFL_CTRL_OV_SEL_BIT = 0;
    localparam int SFL_CTRL_STAT_CLR_BIT = 1;
    localparam int SFL_HB_EN_LSB = 0;
    localparam int SFL_HB_CFG_LSB = 8;
    localparam int SFL_STAT_LATCH_LSB = 0;
    localparam int SFL_STAT_OV_BIT = 8;
    localparam int SFL_STAT_UV_BIT = 9;
    localparam int SFL_STAT_LOCK_BIT = 10;
    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic SFL_OV_SEL_RST = 1'b0;
    localparam int SFL_NUM_CH = 6;
    localparam int SFL_MAX_CH = 8;
    localparam int SFL_SYNC_STAGES = 2;
endpackage

// *** rtl/sfl_sync.sv ***
// two-flop synchroniser for asynchronous pin levels
module sfl_sync
    import sfl_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    if (WIDTH < 1) begin : g_bad_width
        $error("sfl_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (ce) begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

// *** rtl/sfl_top.sv ***
// supply-fault lockout and fault-clear logic for a multi-channel half-bridge driver
module sfl_top
    import sfl_pkg::*;
#(
    parameter int NUM_CH = SFL_NUM_CH
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // register port
    input wire logic [SFL_AW-1:0] reg_addr,
    input wire logic [SFL_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [SFL_DW-1:0] reg_rdata,
    // supply comparators and enable pin, asynchronous
    input wire logic ov_cmp,
    input wire logic uv_cmp,
    input wire logic en_pin,
    // latching faults from protection logic, same clock
    input wire logic [NUM_CH-1:0] fault_latch_req,
    // half-bridge drive
    output logic [NUM_CH-1:0] hb_drive_en,
    output logic [NUM_CH-1:0] hb_high_side,
    // supply status
    output logic supply_ov,
    output logic supply_uv,
    output logic supply_lockout
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (NUM_CH < 1 || NUM_CH > SFL_MAX_CH) begin : g_bad_num_ch
        $error("sfl_top: NUM_CH must be 1..8 to fit the register fields");
    end

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic ov_sync;
    logic uv_sync;
    logic en_sync;

    sfl_sync #(
        .WIDTH(3)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .async_in({en_pin, uv_cmp, ov_cmp}),
        .sync_out({en_sync, uv_sync, ov_sync})
    );

    // ------------------------------------------------------------
    // enable pin cycle detect
    // ------------------------------------------------------------
    logic [1:0] prime_cnt_ff;
    logic primed;
    logic en_prev_ff;
    logic en_rise;

    // synchroniser output is only trusted once it holds a real pin level
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prime_cnt_ff <= 2'h0;
        end else if (ce && !primed) begin
            prime_cnt_ff <= prime_cnt_ff + 2'h1;
        end
    end

    assign primed = (prime_cnt_ff == 2'(SFL_SYNC_STAGES));

    // held high until primed, else a high pin looks like a wake after reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            en_prev_ff <= 1'b1;
        end else if (ce) begin
            en_prev_ff <= primed ? en_sync : 1'b1;
        end
    end

    // wake after a low phase counts as one full cycle of the pin
    assign en_rise = primed & en_sync & ~en_prev_ff;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic wr_hbcfg;
    logic stat_clr_pulse;
    logic fault_clr;
    logic ov_sel_ff;

    assign wr_ctrl = reg_wr & (reg_addr == SFL_CTRL_OFS);
    assign wr_hbcfg = reg_wr & (reg_addr == SFL_HBCFG_OFS);
    assign stat_clr_pulse = wr_ctrl & reg_wdata[SFL_CTRL_STAT_CLR_BIT];
    assign fault_clr = stat_clr_pulse | en_rise;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ov_sel_ff <= SFL_OV_SEL_RST;
        end else if (ce && wr_ctrl) begin
            ov_sel_ff <= reg_wdata[SFL_CTRL_OV_SEL_BIT];
        end
    end

    // ------------------------------------------------------------
    // lockout decision
    // ------------------------------------------------------------
    logic nxt_lockout;
    logic lockout_ff;
    logic ov_flag_ff;
    logic uv_flag_ff;

    // over-voltage only counts when the lockout select is set
    assign nxt_lockout = uv_sync | (ov_sync & ov_sel_ff);

    // flags track the comparators live; nothing is held here
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lockout_ff <= 1'b0;
            ov_flag_ff <= 1'b0;
            uv_flag_ff <= 1'b0;
        end else if (ce) begin
            lockout_ff <= nxt_lockout;
            ov_flag_ff <= ov_sync;
            uv_flag_ff <= uv_sync;
        end
    end

    assign supply_ov = ov_flag_ff;
    assign supply_uv = uv_flag_ff;
    assign supply_lockout = lockout_ff;

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] en_bits;
    logic [NUM_CH-1:0] cfg_bits;
    logic [NUM_CH-1:0] latched;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        sfl_chan u_chan (
            .sys_clk(sys_clk),
            .rst(rst),
            .ce(ce),
            .wr_cfg(wr_hbcfg),
            .wr_en_bit(reg_wdata[SFL_HB_EN_LSB + i]),
            .wr_cfg_bit(reg_wdata[SFL_HB_CFG_LSB + i]),
            .fault_set(fault_latch_req[i]),
            .fault_clr(fault_clr),
            .lockout(lockout_ff),
            .en_ff(en_bits[i]),
            .cfg_ff(cfg_bits[i]),
            .latched_ff(latched[i]),
            .drive_ff(hb_drive_en[i]),
            .side_ff(hb_high_side[i])
        );
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [SFL_DW-1:0] nxt_rdata;
    logic [SFL_DW-1:0] rdata_ff;

    always_comb begin
        nxt_rdata = '0;
        case (reg_addr)
            SFL_CTRL_OFS: begin
                nxt_rdata[SFL_CTRL_OV_SEL_BIT] = ov_sel_ff;
            end
            SFL_HBCFG_OFS: begin
                nxt_rdata[SFL_HB_EN_LSB +: NUM_CH] = en_bits;
                nxt_rdata[SFL_HB_CFG_LSB +: NUM_CH] = cfg_bits;
            end
            SFL_STAT_OFS: begin
                nxt_rdata[SFL_STAT_LATCH_LSB +: NUM_CH] = latched;
                nxt_rdata[SFL_STAT_OV_BIT] = ov_flag_ff;
                nxt_rdata[SFL_STAT_UV_BIT] = uv_flag_ff;
                nxt_rdata[SFL_STAT_LOCK_BIT] = lockout_ff;
            end
            default: begin
                nxt_rdata = '0;
            end
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_ff <= '0;
        end else if (ce) begin
            rdata_ff <= reg_rd ? nxt_rdata : '0;
        end
    end

    assign reg_rdata = rdata_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // supply lockout, supply flags and fault latching
    // ------------------------------------------------------------
    a_ov_sel_clear: assert property (
        ce && !uv_sync && !ov_sel_ff |=> !lockout_ff
    ) else $error("over-voltage locked out with lockout select clear");

    a_ov_lockout_set: assert property (
        ce && ov_sync && ov_sel_ff |=> lockout_ff
    ) else $error("over-voltage with select set did not lock out");

    a_uv_lockout_set: assert property (
        ce && uv_sync |=> lockout_ff
    ) else $error("under-voltage did not lock out");

    a_lockout_hiz: assert property (
        ce && lockout_ff |=> hb_drive_en == '0
    ) else $error("driver on during supply lockout");

    a_lockout_keeps_cfg: assert property (
        ce && lockout_ff && !wr_hbcfg && fault_latch_req == '0
            |=> en_bits == $past(en_bits) && cfg_bits == $past(cfg_bits)
    ) else $error("lockout altered programmed bits");

    a_clear_latched: assert property (
        ce && fault_clr && fault_latch_req == '0 |=> latched == '0
    ) else $error("latched fault survived a clear");

    a_fault_zeroes_cfg: assert property (
        ce && fault_latch_req != '0
            |=> ((en_bits | cfg_bits) & $past(fault_latch_req)) == '0
                && (latched & $past(fault_latch_req)) == $past(fault_latch_req)
    ) else $error("latching fault left enable or config bits set");

    a_auto_recover: assert property (
        ce && !lockout_ff |=> hb_drive_en == $past(en_bits & ~latched)
    ) else $error("driver did not return to programmed state");

    a_live_flags: assert property (
        ce |=> supply_ov == $past(ov_sync) && supply_uv == $past(uv_sync)
    ) else $error("supply flags do not follow comparators");

    a_sel_written: assert property (
        ce && wr_ctrl |=> ov_sel_ff == $past(reg_wdata[SFL_CTRL_OV_SEL_BIT])
    ) else $error("lockout select not taken from write");

    a_supply_release: assert property (
        ce && !uv_sync && !ov_sync |=> !lockout_ff
    ) else $error("lockout held after supply returned");

    a_flags_frozen: assert property (
        !ce |=> supply_ov == $past(supply_ov) && supply_uv == $past(supply_uv)
    ) else $error("supply flags moved while clock enable low");

    a_stat_live: assert property (
        ce && reg_rd && reg_addr == SFL_STAT_OFS
            |=> reg_rdata[SFL_STAT_UV_BIT] == $past(uv_flag_ff)
    ) else $error("status read does not show live under-voltage");

    // ------------------------------------------------------------
    // latched faults and clears
    // ------------------------------------------------------------
    a_clear_on_request: assert property (
        ce && wr_ctrl && reg_wdata[SFL_CTRL_STAT_CLR_BIT] && fault_latch_req == '0
            |=> latched == '0
    ) else $error("status reset request left a latched fault");

    a_clear_on_enable: assert property (
        ce && en_rise && fault_latch_req == '0 |=> latched == '0
    ) else $error("enable pin cycle left a latched fault");

    a_latch_holds: assert property (
        ce && !fault_clr |=> (latched & $past(latched)) == $past(latched)
    ) else $error("latched fault dropped without a clear");

    a_latched_no_drive: assert property (
        ce |=> (hb_drive_en & $past(latched)) == '0
    ) else $error("latched-off channel still driven");

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    c_ov_lockout: cover property (ce && ov_sync && ov_sel_ff ##1 lockout_ff);
    c_ov_ignored: cover property (ov_sync && !ov_sel_ff ##1 hb_drive_en != '0);
    c_uv_recover: cover property (lockout_ff ##1 !lockout_ff ##1 hb_drive_en != '0);
    c_stat_clear: cover property (latched != '0 ##1 stat_clr_pulse ##1 latched == '0);
    c_en_cycle: cover property (en_rise && latched != '0);
endmodule

// *** verif/sfl_host.sv ***
// host-side register master model for the supply-fault lockout bench
module sfl_host
    import sfl_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // register port
    output logic [SFL_AW-1:0] reg_addr,
    output logic [SFL_DW-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [SFL_DW-1:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    // one-cycle write; also carries the status-reset request bit
    task automatic wr(input logic [SFL_AW-1:0] a, input logic [SFL_DW-1:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        // idle data toggled so a stale word is never mistaken for a live one
        reg_wdata <= ~d;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [SFL_AW-1:0] a, output logic [SFL_DW-1:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// *** verif/supply_fault_lockout_tb.sv ***
// self-checking bench for the supply-fault lockout block
module supply_fault_lockout_tb
    import sfl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic ov_cmp = 1'b0;
    logic uv_cmp = 1'b0;
    logic en_pin = 1'b1;
    logic [5:0] fault_latch_req = 6'h00;
    logic [SFL_AW-1:0] reg_addr;
    logic [SFL_DW-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [SFL_DW-1:0] reg_rdata;
    logic [5:0] hb_drive_en;
    logic [5:0] hb_high_side;
    logic supply_ov;
    logic supply_uv;
    logic supply_lockout;
    int err_total = 0;
    int checked = 0;

    always #2.5 sys_clk = ~sys_clk;

    sfl_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    sfl_top #(.NUM_CH(6)) uut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ov_cmp(ov_cmp), .uv_cmp(uv_cmp), .en_pin(en_pin),
        .fault_latch_req(fault_latch_req), .hb_drive_en(hb_drive_en),
        .hb_high_side(hb_high_side), .supply_ov(supply_ov), .supply_uv(supply_uv),
        .supply_lockout(supply_lockout));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [SFL_AW-1:0] a, input logic [31:0] exp);
        logic [SFL_DW-1:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        idle(1);
        chk(32'(hb_drive_en), 32'h0);
        rchk(SFL_STAT_OFS, 32'h0);
        host.wr(SFL_HBCFG_OFS, 32'h0000153F);
        idle(3);
        chk(32'(hb_drive_en), 32'h3F);
        chk(32'(hb_high_side), 32'h15);
        // over-voltage with lockout select clear: flag only
        @(posedge sys_clk) ov_cmp <= 1'b1;
        idle(6);
        chk(32'({supply_ov, supply_lockout}), 32'h2);
        chk(32'(hb_drive_en), 32'h3F);
        rchk(SFL_STAT_OFS, 32'h00000100);
        // select set while over-voltage persists
        host.wr(SFL_CTRL_OFS, 32'h00000001);
        idle(4);
        chk(32'({supply_lockout, hb_drive_en}), 32'h40);
        rchk(SFL_HBCFG_OFS, 32'h0000153F);
        @(posedge sys_clk) ov_cmp <= 1'b0;
        idle(6);
        chk(32'(supply_ov), 32'h0);
        chk(32'(hb_drive_en), 32'h3F);
        @(posedge sys_clk) uv_cmp <= 1'b1;
        idle(6);
        chk(32'({supply_uv, supply_lockout, hb_drive_en}), 32'hC0);
        @(posedge sys_clk) uv_cmp <= 1'b0;
        idle(6);
        chk(32'({supply_uv, hb_drive_en}), 32'h3F);
        rchk(SFL_STAT_OFS, 32'h0);
        // latch channel 2, then clear by status-reset request
        @(posedge sys_clk) fault_latch_req <= 6'h04;
        @(posedge sys_clk) fault_latch_req <= 6'h00;
        idle(2);
        chk(32'(hb_drive_en), 32'h3B);
        rchk(SFL_HBCFG_OFS, 32'h0000113B);
        rchk(SFL_STAT_OFS, 32'h00000004);
        host.wr(SFL_CTRL_OFS, 32'h00000003);
        idle(2);
        rchk(SFL_STAT_OFS, 32'h0);
        rchk(SFL_CTRL_OFS, 32'h00000001);
        chk(32'(hb_drive_en), 32'h3B);
        host.wr(SFL_HBCFG_OFS, 32'h0000153F);
        idle(3);
        chk(32'(hb_drive_en), 32'h3F);
        // latch channel 5 as a level, then clear by enable cycle
        @(posedge sys_clk) fault_latch_req <= 6'h20;
        idle(2);
        @(posedge sys_clk) fault_latch_req <= 6'h00;
        @(posedge sys_clk) en_pin <= 1'b0;
        idle(4);
        @(posedge sys_clk) en_pin <= 1'b1;
        idle(6);
        rchk(SFL_STAT_OFS, 32'h0);
        chk(32'(hb_drive_en), 32'h1F);
        // unmapped and read-only places
        host.wr(4'hC, 32'hFFFFFFFF);
        host.wr(SFL_STAT_OFS, 32'hFFFFFFFF);
        rchk(4'hC, 32'h0);
        rchk(SFL_HBCFG_OFS, 32'h0000151F);
        rchk(SFL_STAT_OFS, 32'h0);
        // clock enable low freezes the supply path
        @(posedge sys_clk) ce <= 1'b0;
        @(posedge sys_clk) uv_cmp <= 1'b1;
        idle(6);
        chk(32'({supply_uv, supply_lockout, hb_drive_en}), 32'h1F);
        @(posedge sys_clk) ce <= 1'b1;
        idle(6);
        chk(32'({supply_uv, supply_lockout, hb_drive_en}), 32'hC0);
        @(posedge sys_clk) uv_cmp <= 1'b0;
        idle(6);
        chk(32'(hb_drive_en), 32'h1F);
        // latch channel 0, then a mid-run reset clears everything
        @(posedge sys_clk) fault_latch_req <= 6'h01;
        @(posedge sys_clk) fault_latch_req <= 6'h00;
        idle(2);
        rchk(SFL_STAT_OFS, 32'h00000001);
        @(posedge sys_clk) rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        idle(3);
        rchk(SFL_STAT_OFS, 32'h0);
        rchk(SFL_CTRL_OFS, 32'h0);
        rchk(SFL_HBCFG_OFS, 32'h0);
        chk(32'(hb_drive_en), 32'h0);
        results();
    end

    // tests need under two hundred cycles; this bound only cuts a hang
    initial begin
        repeat (3000) @(posedge sys_clk);
        err_total++;
        results();
    end
endmodule
